//--- verilog/rss_selector.sv
`include "rss_params.svh"

module rss_selector #(
    parameter int unsigned TASK_CYCLES = `RSS_TASK_CYCLES
) (
    input  wire logic        clk,           // 10 MHz clock
    input  wire logic        rst_n,         // sync reset, active low
    input  wire logic        ce,            // clock enable
    input  wire logic [6:0]  term_sel,      // terminal select bits
    input  wire logic        term_flag,     // terminal timer reset
    input  wire logic [1:0]  nv_option,     // stored power-up option
    input  wire logic [15:0] nv_keypad_ref, // stored keypad reference
    input  wire logic [15:0] nv_first_pre,  // stored preset 1 value
    input  wire logic        wb_cyc_i,      // wishbone cycle
    input  wire logic        wb_stb_i,      // wishbone strobe
    input  wire logic        wb_we_i,       // wishbone write
    input  wire logic [7:0]  wb_adr_i,      // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,      // wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,      // wishbone write data
    output logic      [31:0] wb_dat_o,      // wishbone read data
    output logic             wb_ack_o,      // wishbone acknowledge
    output logic      [2:0]  source_ind,    // reference source 1..5
    output logic      [3:0]  preset_ind,    // preset reference 1..8
    output logic      [15:0] keypad_ref,    // keypad mode reference
    output logic             task_tick      // 4ms task pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    localparam logic [15:0] TASK_LAST = 16'(TASK_CYCLES - 1);

    // input synchronisers, three stages per terminal bit
    logic [7:0] pin_raw;
    logic [7:0] s1_ff;
    logic [7:0] s2_ff;
    logic [7:0] s3_ff;
    logic [7:0] pin_ff;

    assign pin_raw = {term_flag, term_sel};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_ff[gi]  <= 1'b0;
                    s2_ff[gi]  <= 1'b0;
                    s3_ff[gi]  <= 1'b0;
                    pin_ff[gi] <= 1'b0;
                end else if (ce) begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        pin_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    // software registers
    logic [8:0]                   ctrl_ff;
    logic [3:0]                   mode_ff;
    logic [1:0]                   option_ff;
    rss_pkg::rss_ref_t            keyref_ff;
    rss_pkg::rss_ref_t            first_pre_ff;
    rss_pkg::rss_ref_t            period_ff;
    rss_pkg::rss_state_e          state_ff;
    logic                         ack_ff;
    logic [31:0]                  rdat_ff;
    logic                         wr_go;
    logic                         rd_go;

    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
    assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8],
                   sel[0] ? dat[7:0]  : old[7:0]};
    endfunction : merge16

    // effective select bits and flag: software or terminal
    rss_pkg::rss_sel_t eff_sel;
    logic              eff_flag;

    assign eff_sel  = ctrl_ff[`RSS_CTRL_SEL_MSB:`RSS_CTRL_SEL_LSB]
                      | pin_ff[6:0];
    assign eff_flag = ctrl_ff[`RSS_CTRL_FLAG_BIT] | pin_ff[7];

    rss_sel_if sel_if ();
    assign sel_if.sel = eff_sel;

    rss_prio u_prio (
        .sel_if (sel_if.prio)
    );

    // bus slave: one wait cycle, ack for a single cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else if (ce) begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff      <= `RSS_RST_CTRL;
            mode_ff      <= `RSS_RST_MODE;
            period_ff    <= `RSS_RST_PERIOD;
        end else if (ce && wr_go) begin
            case (wb_adr_i)
                `RSS_OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_ff[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        ctrl_ff[8] <= wb_dat_i[8];
                    end
                end
                `RSS_OFF_MODE: begin
                    if (wb_sel_i[0]) begin
                        mode_ff <= wb_dat_i[3:0];
                    end
                end
                `RSS_OFF_PERIOD: begin
                    period_ff <= merge16(period_ff, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    // power-up load of option, preset 1 and keypad reference
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff     <= rss_pkg::st_init;
            option_ff    <= `RSS_RST_OPTION;
            keyref_ff    <= `RSS_RST_REF;
            first_pre_ff <= `RSS_RST_REF;
        end else if (ce) begin
            case (state_ff)
                rss_pkg::st_init: begin
                    option_ff    <= nv_option;
                    first_pre_ff <= nv_first_pre;
                    case (nv_option)
                        `RSS_OPT_LAST:    keyref_ff <= nv_keypad_ref;
                        `RSS_OPT_PRESET1: keyref_ff <= nv_first_pre;
                        default:          keyref_ff <= `RSS_RST_REF;
                    endcase
                    state_ff <= rss_pkg::st_run;
                end
                rss_pkg::st_run: begin
                    if (wr_go) begin
                        case (wb_adr_i)
                            `RSS_OFF_OPTION: begin
                                if (wb_sel_i[0]) begin
                                    option_ff <= wb_dat_i[1:0];
                                end
                            end
                            `RSS_OFF_KEYREF: begin
                                keyref_ff <= merge16(keyref_ff, wb_dat_i,
                                                     wb_sel_i);
                            end
                            `RSS_OFF_PRESET1: begin
                                first_pre_ff <= merge16(first_pre_ff,
                                                        wb_dat_i, wb_sel_i);
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: begin
                    state_ff <= rss_pkg::st_init;
                end
            endcase
        end
    end

    // 4ms task tick
    logic [15:0] task_cnt_ff;
    logic        tick_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            task_cnt_ff <= 16'h0000;
            tick_ff     <= 1'b0;
        end else if (ce) begin
            tick_ff <= (task_cnt_ff == TASK_LAST);
            if (task_cnt_ff == TASK_LAST) begin
                task_cnt_ff <= 16'h0000;
            end else begin
                task_cnt_ff <= task_cnt_ff + 16'h0001;
            end
        end
    end

    // auto preset timer: counts 4ms ticks, steps preset 1..8
    logic [15:0] tmr_cnt_ff;
    logic [2:0]  tmr_idx_ff;
    logic        auto_mode;
    logic        tmr_wrap;

    assign auto_mode = (mode_ff == `RSS_MODE_AUTO_TMR);
    assign tmr_wrap  = (17'(tmr_cnt_ff) + 17'h00001) >= 17'(period_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr_cnt_ff <= 16'h0000;
            tmr_idx_ff <= 3'h0;
        end else if (ce) begin
            if (eff_flag && auto_mode) begin
                tmr_cnt_ff <= 16'h0000;
                tmr_idx_ff <= 3'h0;
            end else if (!eff_flag && tick_ff) begin
                if (tmr_wrap) begin
                    tmr_cnt_ff <= 16'h0000;
                    tmr_idx_ff <= tmr_idx_ff + 3'h1;
                end else begin
                    tmr_cnt_ff <= tmr_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // indicators refreshed on the 4ms task
    logic [2:0] src_ff;
    logic [3:0] pre_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_ff <= `RSS_SRC_DEFAULT;
            pre_ff <= `RSS_PRE_FIRST;
        end else if (ce && tick_ff) begin
            src_ff <= sel_if.src;
            if (auto_mode) begin
                pre_ff <= {1'b0, tmr_idx_ff} + `RSS_PRE_FIRST;
            end else begin
                pre_ff <= {1'b0, sel_if.code} + `RSS_PRE_FIRST;
            end
        end
    end

    // read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_ff <= 32'h00000000;
        end else if (ce && rd_go) begin
            case (wb_adr_i)
                `RSS_OFF_CTRL:    rdat_ff <= {23'h0, ctrl_ff};
                `RSS_OFF_MODE:    rdat_ff <= {28'h0, mode_ff};
                `RSS_OFF_OPTION:  rdat_ff <= {30'h0, option_ff};
                `RSS_OFF_KEYREF:  rdat_ff <= {16'h0, keyref_ff};
                `RSS_OFF_PRESET1: rdat_ff <= {16'h0, first_pre_ff};
                `RSS_OFF_PERIOD:  rdat_ff <= {16'h0, period_ff};
                `RSS_OFF_SRCIND:  rdat_ff <= {29'h0, src_ff};
                `RSS_OFF_PREIND:  rdat_ff <= {28'h0, pre_ff};
                `RSS_OFF_EFFSEL:  rdat_ff <= {24'h0, eff_flag, eff_sel};
                default:          rdat_ff <= 32'h00000000;
            endcase
        end
    end

    assign wb_dat_o   = rdat_ff;
    assign wb_ack_o   = ack_ff;
    assign source_ind = src_ff;
    assign preset_ind = pre_ff;
    assign keypad_ref = keyref_ff;
    assign task_tick  = tick_ff;

    a_src_priority: assert property (
        ce && tick_ff && eff_sel[`RSS_SEL_PRECISION] |=>
        src_ff == `RSS_SRC_PRECISION)
        else $error("precision select did not win");
    a_src_analog2: assert property (
        ce && tick_ff && eff_sel[3:0] == 4'h1 |=> src_ff == `RSS_SRC_ANALOG2)
        else $error("analog-2 select did not give source 2");
    a_src_preset: assert property (
        ce && tick_ff && eff_sel[3:1] == 3'h1 |=> src_ff == `RSS_SRC_PRESET)
        else $error("preset select did not give source 3");
    a_src_keypad: assert property (
        ce && tick_ff && eff_sel[3:2] == 2'h1 |=> src_ff == `RSS_SRC_KEYPAD)
        else $error("keypad select did not give source 4");
    a_src_hold: assert property (
        !(ce && tick_ff) |=> $stable(src_ff))
        else $error("source indicator changed off the task tick");
    a_src_range: assert property (
        src_ff >= 3'h1 && src_ff <= 3'h5)
        else $error("source indicator out of range");
    a_preset_code: assert property (
        ce && tick_ff && !auto_mode |=>
        pre_ff == {1'b0, $past(eff_sel[6:4])} + 4'h1)
        else $error("preset indicator not code plus one");
    a_timer_restart: assert property (
        ce && eff_flag && auto_mode |=> tmr_idx_ff == 3'h0 &&
        tmr_cnt_ff == 16'h0000)
        else $error("timer not restarted by reset flag");
    a_timer_step: assert property (
        ce && !eff_flag && tick_ff && tmr_wrap |=>
        tmr_idx_ff == $past(tmr_idx_ff) + 3'h1)
        else $error("timer did not advance preset");
    a_powerup_zero: assert property (
        ce && state_ff == rss_pkg::st_init && nv_option == `RSS_OPT_ZERO
        |=> keyref_ff == 16'h0000 ##1 state_ff == rss_pkg::st_run)
        else $error("power-up option zero did not clear reference");
endmodule : rss_selector

//--- verilog/rss_params.svh
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// register byte offsets
`define RSS_OFF_CTRL      8'h00
`define RSS_OFF_MODE      8'h04
`define RSS_OFF_OPTION    8'h08
`define RSS_OFF_KEYREF    8'h0C
`define RSS_OFF_PRESET1   8'h10
`define RSS_OFF_PERIOD    8'h14
`define RSS_OFF_SRCIND    8'h18
`define RSS_OFF_PREIND    8'h1C
`define RSS_OFF_EFFSEL    8'h20

// control register fields
`define RSS_CTRL_SEL_LSB  0
`define RSS_CTRL_SEL_MSB  6
`define RSS_CTRL_FLAG_BIT 8

// select bit positions
`define RSS_SEL_ANALOG2   0
`define RSS_SEL_PRESET    1
`define RSS_SEL_KEYPAD    2
`define RSS_SEL_PRECISION 3
`define RSS_SEL_CODE_LSB  4
`define RSS_SEL_CODE_MSB  6

// indicator codes
`define RSS_SRC_DEFAULT   3'h1
`define RSS_SRC_ANALOG2   3'h2
`define RSS_SRC_PRESET    3'h3
`define RSS_SRC_KEYPAD    3'h4
`define RSS_SRC_PRECISION 3'h5
`define RSS_PRE_FIRST     4'h1

// preset mode selector value for auto preset timer
`define RSS_MODE_AUTO_TMR 4'h9

// power-up keypad reference options
`define RSS_OPT_ZERO      2'h0
`define RSS_OPT_LAST      2'h1
`define RSS_OPT_PRESET1   2'h2

// reset values
`define RSS_RST_CTRL      9'h000
`define RSS_RST_MODE      4'h0
`define RSS_RST_OPTION    2'h0
`define RSS_RST_REF       16'h0000
`define RSS_RST_PERIOD    16'h0001

// timing
`define RSS_CLK_NS        100
`define RSS_TASK_NS       4000000
`define RSS_TASK_CYCLES   (`RSS_TASK_NS / `RSS_CLK_NS)

`endif

//--- verilog/rss_pkg.sv
package rss_pkg;
    typedef logic [2:0]  rss_src_t;
    typedef logic [3:0]  rss_pre_t;
    typedef logic [6:0]  rss_sel_t;
    typedef logic [15:0] rss_ref_t;

    typedef enum logic {
        st_init,
        st_run
    } rss_state_e;
endpackage : rss_pkg

//--- verilog/rss_sel_if.sv
interface rss_sel_if;
    rss_pkg::rss_sel_t sel;
    rss_pkg::rss_src_t src;
    logic [2:0]        code;

    modport prio (input sel, output src, output code);
    modport user (output sel, input src, input code);
endinterface : rss_sel_if

//--- verilog/rss_prio.sv
`include "rss_params.svh"

module rss_prio (
    rss_sel_if.prio sel_if    // select bits in, codes out
);
    always_comb begin
        if (sel_if.sel[`RSS_SEL_PRECISION]) begin
            sel_if.src = `RSS_SRC_PRECISION;
        end else if (sel_if.sel[`RSS_SEL_KEYPAD]) begin
            sel_if.src = `RSS_SRC_KEYPAD;
        end else if (sel_if.sel[`RSS_SEL_PRESET]) begin
            sel_if.src = `RSS_SRC_PRESET;
        end else if (sel_if.sel[`RSS_SEL_ANALOG2]) begin
            sel_if.src = `RSS_SRC_ANALOG2;
        end else begin
            sel_if.src = `RSS_SRC_DEFAULT;
        end
    end

    // bit 0, 1, 2 of the code in order
    assign sel_if.code = sel_if.sel[`RSS_SEL_CODE_MSB:`RSS_SEL_CODE_LSB];
endmodule : rss_prio

//--- tb/testbench.sv
`include "rss_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TC = 10;

    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [6:0]  term_sel;
    logic        term_flag;
    logic [1:0]  nv_option;
    logic [15:0] nv_keypad_ref;
    logic [15:0] nv_first_pre;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [2:0]  source_ind;
    logic [3:0]  preset_ind;
    logic [15:0] keypad_ref;
    logic        task_tick;
    int          n_errors;
    int          num_checks;
    int          seed;

    rss_selector #(.TASK_CYCLES(TC)) rss_selector_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .term_sel(term_sel),
        .term_flag(term_flag), .nv_option(nv_option),
        .nv_keypad_ref(nv_keypad_ref), .nv_first_pre(nv_first_pre),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_ind(source_ind),
        .preset_ind(preset_ind), .keypad_ref(keypad_ref),
        .task_tick(task_tick)
    );

    always #50 clk = ~clk;

    function automatic rss_pkg::rss_src_t exp_src(input logic [6:0] s);
        if (s[3]) return 3'h5;
        if (s[2]) return 3'h4;
        if (s[1]) return 3'h3;
        if (s[0]) return 3'h2;
        return 3'h1;
    endfunction : exp_src

    task automatic chk_ind(input string nm, input logic [15:0] e,
                           input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_ind

    task automatic chk_bus(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_bus

    // one classic cycle, entered and left just after a rising edge
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= d;
        wb_sel <= 4'hF;
        // no wait limit here: only the watchdog ends a stuck cycle
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb(1'b0, adr, 32'h0, q);
    endtask : rd

    task automatic wait_tick;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (task_tick !== 1'b1 && n < 4 * TC);
        if (n >= 4 * TC) begin
            n_errors++;
            $display("FAIL task_tick expected 1 seen timeout");
            final_report;
        end
    endtask : wait_tick

    task automatic settle;
        wait_tick;
        wait_tick;
        @(posedge clk);
    endtask : settle

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk_ind("rst source_ind", 16'h1, source_ind);
        chk_ind("rst preset_ind", 16'h1, preset_ind);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
    endtask : do_reset

    task automatic t_regs;
        logic [7:0]  ra [7];
        logic [31:0] rv [7];
        logic [31:0] q;
        int          n;
        ra = '{`RSS_OFF_CTRL, `RSS_OFF_MODE, `RSS_OFF_OPTION,
               `RSS_OFF_PERIOD, `RSS_OFF_SRCIND, `RSS_OFF_PREIND, 8'h24};
        rv = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], q);
            chk_bus("reset value", rv[i], q);
        end
        wr(`RSS_OFF_OPTION, 32'hFFFFFFFF);
        rd(`RSS_OFF_OPTION, q);
        chk_bus("option rw", 32'h3, q);
        wr(`RSS_OFF_SRCIND, 32'h7);
        rd(`RSS_OFF_SRCIND, q);
        chk_bus("srcind ro", 32'h1, q);
        wr(`RSS_OFF_PREIND, 32'hF);
        rd(`RSS_OFF_PREIND, q);
        chk_bus("preind ro", 32'h1, q);
        wr(8'h24, 32'h5A5A5A5A);
        rd(8'h24, q);
        chk_bus("unmapped", 32'h0, q);
        wr(`RSS_OFF_KEYREF, 32'h1234ABCD);
        rd(`RSS_OFF_KEYREF, q);
        chk_bus("keyref rw", 32'hABCD, q);
        chk_ind("keypad_ref", 16'hABCD, keypad_ref);
        wr(`RSS_OFF_PRESET1, 32'hFFFF5A5A);
        rd(`RSS_OFF_PRESET1, q);
        chk_bus("preset1 rw", 32'h5A5A, q);
        wait_tick;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (task_tick !== 1'b1 && n < 4 * TC);
        chk_ind("tick period", 16'(TC), 16'(n));
        // clock enable low must freeze the task counter
        ce <= 1'b0;
        n = 0;
        repeat (2 * TC) begin
            @(posedge clk);
            if (task_tick === 1'b1) n++;
        end
        ce <= 1'b1;
        chk_ind("ce freeze", 16'h0, 16'(n));
        $display("test regs done, errors %0d", n_errors);
    endtask : t_regs

    task automatic t_prio;
        logic [6:0]  s;
        logic [6:0]  r;
        logic [31:0] q;
        for (int i = 0; i < 28; i++) begin
            s = 7'($random(seed));
            if (i < 16) s[3:0] = 4'(i);
            r = 7'($random(seed));
            term_sel <= s & ~r;
            wr(`RSS_OFF_CTRL, {25'h0, s & r});
            settle;
            chk_ind("source_ind", exp_src(s), source_ind);
            chk_ind("preset_ind", {1'b0, s[6:4]} + 4'h1, preset_ind);
            rd(`RSS_OFF_EFFSEL, q);
            chk_bus("effsel", {25'h0, s}, q);
            rd(`RSS_OFF_PREIND, q);
            chk_bus("preind", {29'h0, s[6:4]} + 32'h1, q);
        end
        wait_tick;
        term_sel <= 7'h0;
        wr(`RSS_OFF_CTRL, 32'h08);
        chk_ind("between ticks", exp_src(s), source_ind);
        settle;
        chk_ind("precision", 16'h5, source_ind);
        $display("test prio done, errors %0d", n_errors);
    endtask : t_prio

    task automatic t_timer;
        logic [3:0] prev;
        wr(`RSS_OFF_MODE, 32'h9);
        wr(`RSS_OFF_PERIOD, 32'h1);
        wr(`RSS_OFF_CTRL, 32'h100);
        settle;
        chk_ind("flag preset", 16'h1, preset_ind);
        wait_tick;
        @(posedge clk);
        chk_ind("flag hold", 16'h1, preset_ind);
        wr(`RSS_OFF_CTRL, 32'h0);
        term_flag <= 1'b1;
        settle;
        chk_ind("term flag", 16'h1, preset_ind);
        term_flag <= 1'b0;
        settle;
        prev = preset_ind;
        for (int i = 0; i < 10; i++) begin
            wait_tick;
            @(posedge clk);
            chk_ind("timer step", (prev == 4'h8) ? 16'h1 : 16'(prev + 4'h1),
                    preset_ind);
            prev = preset_ind;
        end
        wr(`RSS_OFF_MODE, 32'h0);
        $display("test timer done, errors %0d", n_errors);
    endtask : t_timer

    task automatic t_power;
        logic [15:0] e;
        for (int o = 0; o < 4; o++) begin
            nv_option     <= 2'(o);
            nv_keypad_ref <= 16'($random(seed));
            nv_first_pre  <= 16'($random(seed));
            do_reset;
            e = (o == 1) ? nv_keypad_ref : (o == 2) ? nv_first_pre : 16'h0;
            chk_ind("keypad_ref", e, keypad_ref);
        end
        $display("test power done, errors %0d", n_errors);
    endtask : t_power

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        seed          = 32'hFED2F6C4;
        clk           = 1'b0;
        rst_n         = 1'b0;
        ce            = 1'b1;
        term_sel      = 7'h0;
        term_flag     = 1'b0;
        nv_option     = 2'h0;
        nv_keypad_ref = 16'h1234;
        nv_first_pre  = 16'h0ABC;
        wb_cyc        = 1'b0;
        wb_stb        = 1'b0;
        wb_we         = 1'b0;
        wb_adr        = 8'h00;
        wb_sel        = 4'h0;
        wb_dat        = 32'h0;
        n_errors      = 0;
        num_checks    = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        t_regs;
        t_prio;
        t_timer;
        t_power;
        final_report;
    end

    initial begin
        #3000000;
        n_errors++;
        final_report;
    end
endmodule : testbench
